// ===== ptc_timer.sv
// Prescaled 8-bit timer with configuration registers and interrupt select
//
// Summary of operation
// [R1] Software enables or disables the counter interrupt.
// [R2] Four interrupt modes: stop, rising, falling, both output edges.
// [R3] Source bit 0 picks counter stop; 1 picks periodic output edges.
// [R4] Fall enable bit 1 interrupts on each falling output edge.
// [R5] Rise enable bit 2 interrupts on rising edges; both bits both.
// [R6] A counter interrupt also raises the wake request.
// [R7] Prescaler start value is built from low and high byte registers.
// [R8] Control bit 0 drives internal clear, bit 1 internal run.
// [R9] Control source select picks internal bits or external pins.
// [R10] Gate mode select: 0 edge mode, 1 level mode.
// [R11] Count clock select: 0 core clock, 1 external count clock.
// [R12] Output frequency is count rate over prescaler times counter.
// [R13] Wave select 1 gives square wave, 0 one prescaler-period pulse.
// [R14] Invert bit 6 inverts the periodic output.
// [R15] Reload bit 3 picks register value (1) or inference output (0).
// [R16] Inference select bit 4 picks inference output 0 or 1.
// [R17] Level mode counts while gate high, captures count when low.
// [R18] Edge mode: after clear, first rising gate edge starts, next rising edge stops.
// [R19] Counter increments on each prescaler tick.
// [R20] Clear from pin, reset or internal bit zeroes the counter.
// [R21] On terminal count prescaler and counter reload, output advances.
`timescale 1ns/10ps
`include "ptc_map.svh"

module ptc_timer
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Register bus
  input wire ptc_pkg::ptc_bus_req_t BUS_REQ,
  output logic [7:0] BUS_RDATA,
  // External pins, asynchronous to the core clock
  input wire ptc_pkg::ptc_pins_t EXT_PINS,
  // Inference core outputs
  input wire logic [7:0] INFERENCE_OUT0,
  input wire logic [7:0] INFERENCE_OUT1,
  // Timer outputs
  output logic PERIODIC_OUTPUT,
  output logic COUNTER_IRQ,
  output logic WAKE_REQUEST
);
  import ptc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] prescaler_low_byte;
  logic [7:0] prescaler_high_byte;
  logic [7:0] timer_control;
  logic [7:0] irq_select;
  logic [7:0] reload_value;
  logic [7:0] counter;
  logic [7:0] capture;
  logic [15:0] presc_cnt;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic clk_prev;
  logic run_prev;
  logic running;
  logic next_running;
  ptc_gate_state_t gate_state;
  ptc_gate_state_t next_gate_state;
  logic pulse_flag;
  logic out_prev;
  logic [15:0] presc_start;
  logic [7:0] count_start;
  logic [7:0] half_point;
  logic clear_sig;
  logic run_sig;
  logic count_en;
  logic count_step;
  logic prescaler_tick;
  logic terminal;
  logic stop_evt;
  logic raw_wave;
  logic out_rise;
  logic out_fall;
  logic next_irq;
  logic wr_counter;

  // Rising edge of a sampled level
  function automatic logic ptc_rise(input logic cur, input logic prev);
    ptc_rise = cur & ~prev;
  endfunction : ptc_rise

  // Register write decode
  function automatic logic ptc_wr_hit(input ptc_bus_req_t req,
                                      input logic [2:0] ofs);
    ptc_wr_hit = req.wr && (req.addr == ofs);
  endfunction : ptc_wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= EXT_PINS;
      pin_sync <= pin_meta;
    end
  end

  // Edge history of synchronised clock and gate
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      clk_prev <= 1'b0;
      run_prev <= 1'b0;
    end
    else
    begin
      clk_prev <= pin_sync[2];
      run_prev <= run_sig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      prescaler_low_byte <= `PTC_RST_PRESC_BYTE;
      prescaler_high_byte <= `PTC_RST_PRESC_BYTE;
      timer_control <= `PTC_RST_CONTROL;
      irq_select <= `PTC_RST_IRQ_SELECT;
      reload_value <= `PTC_RST_RELOAD;
    end
    else
    begin
      if (ptc_wr_hit(BUS_REQ, `PTC_OFS_PRESC_LOW))
        prescaler_low_byte <= BUS_REQ.wdata;
      if (ptc_wr_hit(BUS_REQ, `PTC_OFS_PRESC_HIGH))
        prescaler_high_byte <= BUS_REQ.wdata;
      if (ptc_wr_hit(BUS_REQ, `PTC_OFS_CONTROL))
        timer_control <= {1'b0, BUS_REQ.wdata[6:0]};
      if (ptc_wr_hit(BUS_REQ, `PTC_OFS_IRQ_SELECT))
        irq_select <= {2'b00, BUS_REQ.wdata[5:0]};
      if (ptc_wr_hit(BUS_REQ, `PTC_OFS_RELOAD_VALUE))
        reload_value <= BUS_REQ.wdata;
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      BUS_RDATA <= 8'h00;
    else if (BUS_REQ.rd)
    begin
      case (BUS_REQ.addr)
        `PTC_OFS_PRESC_LOW: BUS_RDATA <= prescaler_low_byte;
        `PTC_OFS_PRESC_HIGH: BUS_RDATA <= prescaler_high_byte;
        `PTC_OFS_CONTROL: BUS_RDATA <= timer_control;
        `PTC_OFS_IRQ_SELECT: BUS_RDATA <= irq_select;
        `PTC_OFS_COUNTER: BUS_RDATA <= counter;
        `PTC_OFS_CAPTURE: BUS_RDATA <= capture;
        `PTC_OFS_RELOAD_VALUE: BUS_RDATA <= reload_value;
        `PTC_OFS_STATUS: BUS_RDATA <= {5'h00,
          gate_state == PTC_GATE_ARMED, PERIODIC_OUTPUT, running};
        default: BUS_RDATA <= 8'h00;
      endcase
    end
    else
      BUS_RDATA <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection for start values, clear, run and count clock
  always_comb
  begin
    presc_start = {prescaler_high_byte, prescaler_low_byte}; // R7
    if (irq_select[`PTC_IRQ_RELOAD_BIT])
      count_start = reload_value; // R15
    else if (irq_select[`PTC_IRQ_FZ_SEL_BIT])
      count_start = INFERENCE_OUT1; // R16
    else
      count_start = INFERENCE_OUT0; // R16
    // A start of zero means a full 256-tick cycle
    half_point = (count_start == 8'h00) ? 8'h80 : {1'b0, count_start[7:1]};
    if (timer_control[`PTC_CTL_SRC_BIT])
    begin
      clear_sig = pin_sync[0]; // R9
      run_sig = pin_sync[1]; // R9
    end
    else
    begin
      clear_sig = timer_control[`PTC_CTL_CLEAR_BIT]; // R8
      run_sig = timer_control[`PTC_CTL_RUN_BIT]; // R8
    end
    // External clock counts on its synchronised rising edge only
    count_en = timer_control[`PTC_CTL_CLK_SEL_BIT] ?
               ptc_rise(pin_sync[2], clk_prev) : 1'b1; // R11
    wr_counter = ptc_wr_hit(BUS_REQ, `PTC_OFS_COUNTER);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run gate: level follows the gate, edge mode walks a sequence
  always_comb
  begin
    next_gate_state = gate_state;
    if (clear_sig)
      next_gate_state = PTC_GATE_ARMED;
    else if (ptc_rise(run_sig, run_prev))
    begin
      case (gate_state)
        PTC_GATE_ARMED: next_gate_state = PTC_GATE_COUNT; // R18
        PTC_GATE_COUNT: next_gate_state = PTC_GATE_HELD; // R18
        PTC_GATE_HELD: next_gate_state = PTC_GATE_HELD;
        default: next_gate_state = PTC_GATE_ARMED;
      endcase
    end
    if (timer_control[`PTC_CTL_GATE_MODE_BIT])
      next_running = run_sig; // R10 R17
    else
      next_running = (next_gate_state == PTC_GATE_COUNT); // R10
    stop_evt = running && !next_running;
    // No step in the stopping cycle, so capture sees the final count
    count_step = running && next_running && count_en; // R17
    prescaler_tick = count_step && (presc_cnt == 16'h0001);
    terminal = prescaler_tick && ((counter + 8'h01) == count_start);
  end

  // Gate state and run flag
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      gate_state <= PTC_GATE_ARMED;
      running <= 1'b0;
    end
    else
    begin
      gate_state <= next_gate_state;
      running <= next_running;
    end
  end

  // Count captured when counting stops
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      capture <= 8'h00;
    else if (stop_evt)
      capture <= counter; // R17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler down counter; a start of zero divides by 65536
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      presc_cnt <= `PTC_RST_PRESC;
    else if (clear_sig)
      presc_cnt <= presc_start;
    else if (prescaler_tick)
      presc_cnt <= presc_start; // R21
    else if (count_step)
      presc_cnt <= presc_cnt - 16'h0001; // R12
  end

  // Main counter; clear beats a software write
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      counter <= `PTC_RST_COUNTER; // R20
    else if (clear_sig)
      counter <= 8'h00; // R20
    else if (wr_counter)
      counter <= BUS_REQ.wdata;
    else if (terminal)
      counter <= 8'h00; // R21
    else if (prescaler_tick)
      counter <= counter + 8'h01; // R19
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output waveform
  // Pulse lasts from terminal count to the next prescaler tick
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pulse_flag <= 1'b0;
    else if (clear_sig)
      pulse_flag <= 1'b0;
    else if (prescaler_tick)
      pulse_flag <= terminal; // R13 R21
  end

  // Square wave is high for the upper half of each count cycle
  assign raw_wave = timer_control[`PTC_CTL_WAVE_BIT] ?
                    (counter >= half_point) : pulse_flag; // R13

  // Registered output with polarity
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PERIODIC_OUTPUT <= 1'b0;
      out_prev <= 1'b0;
    end
    else
    begin
      PERIODIC_OUTPUT <= raw_wave ^ timer_control[`PTC_CTL_INVERT_BIT]; // R14
      out_prev <= PERIODIC_OUTPUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mode selection
  always_comb
  begin
    out_rise = ptc_rise(PERIODIC_OUTPUT, out_prev);
    out_fall = ptc_rise(out_prev, PERIODIC_OUTPUT);
    if (irq_select[`PTC_IRQ_SRC_BIT])
      next_irq = (out_rise && irq_select[`PTC_IRQ_RISE_BIT]) || // R5
                 (out_fall && irq_select[`PTC_IRQ_FALL_BIT]); // R4
    else
      next_irq = stop_evt; // R3
    next_irq = next_irq && irq_select[`PTC_IRQ_ENABLE_BIT]; // R1 R2
  end

  // One-cycle interrupt pulse, mirrored onto the wake request
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      COUNTER_IRQ <= 1'b0;
      WAKE_REQUEST <= 1'b0;
    end
    else
    begin
      COUNTER_IRQ <= next_irq;
      WAKE_REQUEST <= next_irq; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  irq_disabled_a: assert property ( // R1
    !irq_select[`PTC_IRQ_ENABLE_BIT] |=> !COUNTER_IRQ)
    else $error("interrupt raised while disabled");

  irq_stop_a: assert property ( // R3
    stop_evt && !irq_select[`PTC_IRQ_SRC_BIT]
    && irq_select[`PTC_IRQ_ENABLE_BIT] |=> COUNTER_IRQ)
    else $error("no interrupt on counter stop");

  irq_fall_a: assert property ( // R4
    $fell(PERIODIC_OUTPUT) && irq_select[`PTC_IRQ_SRC_BIT]
    && irq_select[`PTC_IRQ_FALL_BIT] && irq_select[`PTC_IRQ_ENABLE_BIT]
    |=> COUNTER_IRQ)
    else $error("no interrupt on falling output edge");

  irq_rise_a: assert property ( // R5
    $rose(PERIODIC_OUTPUT) && irq_select[`PTC_IRQ_SRC_BIT]
    && irq_select[`PTC_IRQ_RISE_BIT] && irq_select[`PTC_IRQ_ENABLE_BIT]
    |=> COUNTER_IRQ)
    else $error("no interrupt on rising output edge");

  wake_follow_a: assert property ( // R6
    WAKE_REQUEST == COUNTER_IRQ)
    else $error("wake request differs from interrupt");

  clear_zero_a: assert property ( // R20
    clear_sig |=> counter == 8'h00)
    else $error("counter not cleared");

  tick_incr_a: assert property ( // R19
    prescaler_tick && !terminal && !clear_sig && !wr_counter
    |=> counter == $past(counter) + 8'h01)
    else $error("counter did not increment on tick");

  stop_capture_a: assert property ( // R17
    stop_evt |=> capture == $past(counter))
    else $error("count not captured on stop");

  level_gate_a: assert property ( // R10
    timer_control[`PTC_CTL_GATE_MODE_BIT] |=> running == $past(run_sig))
    else $error("level mode run does not follow gate");

  output_pol_a: assert property ( // R14
    ##1 PERIODIC_OUTPUT ==
    $past(raw_wave ^ timer_control[`PTC_CTL_INVERT_BIT]))
    else $error("output polarity wrong");

  cover_terminal_c: cover property (terminal ##[1:300] terminal);
  cover_edge_stop_c: cover property (
    gate_state == PTC_GATE_COUNT ##1 gate_state == PTC_GATE_HELD);
  cover_edge_irq_c: cover property (
    irq_select[`PTC_IRQ_SRC_BIT] && COUNTER_IRQ);

endmodule : ptc_timer

// ===== ptc_map.svh
// Register offsets, field positions and reset values of the timer block
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH

// Register offsets (3-bit address)
`define PTC_OFS_PRESC_LOW 3'h0
`define PTC_OFS_PRESC_HIGH 3'h1
`define PTC_OFS_CONTROL 3'h2
`define PTC_OFS_IRQ_SELECT 3'h3
`define PTC_OFS_COUNTER 3'h4
`define PTC_OFS_CAPTURE 3'h5
`define PTC_OFS_RELOAD_VALUE 3'h6
`define PTC_OFS_STATUS 3'h7

// Control register field positions
`define PTC_CTL_CLEAR_BIT 0
`define PTC_CTL_RUN_BIT 1
`define PTC_CTL_SRC_BIT 2
`define PTC_CTL_GATE_MODE_BIT 3
`define PTC_CTL_CLK_SEL_BIT 4
`define PTC_CTL_WAVE_BIT 5
`define PTC_CTL_INVERT_BIT 6

// Interrupt and reload select field positions
`define PTC_IRQ_SRC_BIT 0
`define PTC_IRQ_FALL_BIT 1
`define PTC_IRQ_RISE_BIT 2
`define PTC_IRQ_RELOAD_BIT 3
`define PTC_IRQ_FZ_SEL_BIT 4
`define PTC_IRQ_ENABLE_BIT 5

// Status register field positions
`define PTC_STS_RUNNING_BIT 0
`define PTC_STS_WAVE_BIT 1
`define PTC_STS_ARMED_BIT 2

// Reset values
`define PTC_RST_PRESC 16'h0000
`define PTC_RST_PRESC_BYTE 8'h00
`define PTC_RST_CONTROL 8'h00
`define PTC_RST_IRQ_SELECT 8'h00
`define PTC_RST_COUNTER 8'h00
`define PTC_RST_RELOAD 8'h00

`endif

// ===== ptc_pkg.sv
// Types shared by the prescaled timer block
package ptc_pkg;

  // Register bus request from software
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptc_bus_req_t;

  // External control pins, already in pin order
  typedef struct packed {
    logic count_clock;
    logic run;
    logic clear;
  } ptc_pins_t;

  // Edge-mode gate sequence
  typedef enum logic [1:0] {
    PTC_GATE_ARMED = 2'b00,
    PTC_GATE_COUNT = 2'b01,
    PTC_GATE_HELD = 2'b10
  } ptc_gate_state_t;

endpackage : ptc_pkg

// ===== ptc_pin_src.sv
// External pin source model: gate, clear and count clock for the timer
`timescale 1ns/10ps

module ptc_pin_src
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Commands from the bench
  input wire logic clk_on,
  input wire logic run_lvl,
  input wire logic clr_lvl,
  // Pins toward the timer
  output ptc_pkg::ptc_pins_t pins
);
  import ptc_pkg::*;

  logic [1:0] div;

  ////////////////////////////////////////////////////////////////////////////
  // Count clock of four core cycles; stands still while not asked for
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      div <= 2'h0;
    else if (clk_on)
      div <= div + 2'h1;

  // Gate and clear follow the bench levels, as a slow outside source would
  assign pins = '{count_clock: div[1],
                  run: run_lvl,
                  clear: clr_lvl};

endmodule : ptc_pin_src

// ===== ptc_timer_tb.sv
// Self-checking bench for the prescaled timer
`timescale 1ns/10ps
`include "ptc_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end

module ptc_timer_tb;
  import ptc_pkg::*;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  ptc_bus_req_t bus = '0;
  logic [7:0] rdata;
  ptc_pins_t pins;
  logic [7:0] inf0 = 8'h02;
  logic [7:0] inf1 = 8'h08;
  logic pout;
  logic irq;
  logic wake;
  logic clk_on = 1'b0;
  logic run_lvl = 1'b0;
  logic clr_lvl = 1'b0;
  logic prev = 1'b0;
  int bad_count = 0;
  int n_checks = 0;
  int rises = 0;
  int highs = 0;
  int irqs = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns
  always #20 core_clk = ~core_clk;

  ptc_timer ptc_timer_i (.CORE_CLK(core_clk), .ARST_N(arst_n),
    .BUS_REQ(bus), .BUS_RDATA(rdata), .EXT_PINS(pins),
    .INFERENCE_OUT0(inf0), .INFERENCE_OUT1(inf1),
    .PERIODIC_OUTPUT(pout), .COUNTER_IRQ(irq), .WAKE_REQUEST(wake));

  ptc_pin_src ptc_pin_src_i (.clk(core_clk), .arst_n(arst_n),
    .clk_on(clk_on), .run_lvl(run_lvl), .clr_lvl(clr_lvl), .pins(pins));

  // Waveform monitor; sampled before the edge's own updates land
  always @(posedge core_clk)
  begin
    if (pout === 1'b1 && prev === 1'b0) rises++;
    if (pout === 1'b1) highs++;
    if (irq === 1'b1) irqs++;
    prev = pout;
    `CHK(wake, irq)
  end

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Bus write, entered just after an edge; one idle cycle follows
  task wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask : wr

  // Bus read: data stand only in the cycle after the strobe
  task rd(input logic [2:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
    d = rdata;
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, read-only places and unused bits
  task t_regs;
    logic [7:0] d;
    logic [7:0] rst_exp [8];
    rst_exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
    for (int i = 0; i < 8; i++)
    begin
      rd(i[2:0], d);
      `CHK(d, rst_exp[i])
    end
    wr(`PTC_OFS_CONTROL, 8'h80);
    rd(`PTC_OFS_CONTROL, d);
    `CHK(d, 8'h00)
    wr(`PTC_OFS_IRQ_SELECT, 8'hc0);
    rd(`PTC_OFS_IRQ_SELECT, d);
    `CHK(d, 8'h00)
    wr(`PTC_OFS_CAPTURE, 8'h77);
    rd(`PTC_OFS_CAPTURE, d);
    `CHK(d, 8'h00)
    wr(`PTC_OFS_PRESC_LOW, 8'ha5);
    wr(`PTC_OFS_PRESC_HIGH, 8'h5a);
    rd(`PTC_OFS_PRESC_LOW, d);
    `CHK(d, 8'ha5)
    rd(`PTC_OFS_PRESC_HIGH, d);
    `CHK(d, 8'h5a)
    // Start value of two count steps keeps every period short
    wr(`PTC_OFS_PRESC_LOW, 8'h02);
    wr(`PTC_OFS_PRESC_HIGH, 8'h00);
    wr(`PTC_OFS_RELOAD_VALUE, 8'h04);
  endtask : t_regs

  // Clear, run, then count edges and interrupts over a 32-cycle window
  task t_case(input logic [7:0] c, input logic [7:0] q,
              input int er, input int eh, input int ei);
    int r0;
    int h0;
    int i0;
    wr(`PTC_OFS_IRQ_SELECT, q);
    wr(`PTC_OFS_CONTROL, c | 8'h01);
    wr(`PTC_OFS_CONTROL, c);
    cyc(40);
    r0 = rises;
    h0 = highs;
    i0 = irqs;
    cyc(32);
    `CHK(rises - r0, er)
    `CHK(highs - h0, eh)
    `CHK(irqs - i0, ei)
  endtask : t_case

  // Stop interrupt, capture on stop, clear by control bit
  task t_stop;
    logic [7:0] a;
    logic [7:0] b;
    int i0;
    wr(`PTC_OFS_IRQ_SELECT, 8'h28);
    wr(`PTC_OFS_CONTROL, 8'h0b);
    wr(`PTC_OFS_CONTROL, 8'h0a);
    cyc(11);
    i0 = irqs;
    wr(`PTC_OFS_CONTROL, 8'h08);
    cyc(4);
    `CHK(irqs - i0, 1)
    rd(`PTC_OFS_COUNTER, a);
    rd(`PTC_OFS_CAPTURE, b);
    `CHK(b, a)
    wr(`PTC_OFS_CONTROL, 8'h09);
    rd(`PTC_OFS_COUNTER, a);
    `CHK(a, 8'h00)
  endtask : t_stop

  // Gate and clear from the pins, edge mode then level mode
  task t_pins;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] runs [5];
    runs = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    wr(`PTC_OFS_CONTROL, 8'h04);
    wr(`PTC_OFS_COUNTER, 8'h33);
    clr_lvl <= 1'b1;
    cyc(6);
    clr_lvl <= 1'b0;
    cyc(6);
    rd(`PTC_OFS_COUNTER, d);
    `CHK(d, 8'h00)
    // Rise, fall, rise, fall: the first rise starts counting, the second stops it
    for (int i = 0; i < 5; i++)
    begin
      if (i > 0) run_lvl <= ~run_lvl;
      cyc(6);
      rd(`PTC_OFS_STATUS, d);
      `CHK(d & 8'h01, runs[i])
    end
    rd(`PTC_OFS_COUNTER, d);
    cyc(8);
    rd(`PTC_OFS_COUNTER, e);
    `CHK(e, d)
    wr(`PTC_OFS_CONTROL, 8'h0c);
    run_lvl <= 1'b1;
    cyc(6);
    rd(`PTC_OFS_STATUS, d);
    `CHK(d & 8'h01, 8'h01)
    run_lvl <= 1'b0;
    cyc(6);
    rd(`PTC_OFS_STATUS, d);
    `CHK(d & 8'h01, 8'h00)
  endtask : t_pins

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(2);
    `CHK({pout, irq, wake, rdata}, 11'h000)
    cyc(2);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_case(8'h2a, 8'h08, 4, 16, 0);
    t_case(8'h0a, 8'h2d, 4, 8, 4);
    t_case(8'h4a, 8'h2b, 4, 24, 4);
    t_case(8'h2a, 8'h2f, 4, 16, 8);
    t_case(8'h2a, 8'h0f, 4, 16, 0);
    t_case(8'h2a, 8'h28, 4, 16, 0);
    t_case(8'h2a, 8'h00, 8, 16, 0);
    t_case(8'h2a, 8'h10, 2, 16, 0);
    clk_on <= 1'b1;
    t_case(8'h3a, 8'h08, 1, 16, 0);
    clk_on <= 1'b0;
    t_stop;
    t_pins;
    end_sim;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    end_sim;
  end

endmodule : ptc_timer_tb
